// [rtl/pot_pkg.sv]
/*
  constants shared by the quad pot two-wire slave design.
  assumes a 25 MHz system clock.
*/
package pot_pkg;
  localparam int          CH_NUM        = 4;
  localparam int          SET_NUM       = 4;
  localparam int          DATA_W        = 8;
  localparam int          CLK_HZ        = 25_000_000;
  localparam int          NV_WRITE_MS   = 10;
  localparam int          NV_WRITE_CYC  = NV_WRITE_MS * (CLK_HZ / 1000);
  localparam logic [3:0]  DEV_TYPE_ID   = 4'hA; // arbitrary value
  localparam int          OP_MSB        = 7;
  localparam int          OP_LSB        = 4;
  localparam int          SEL_MSB       = 3;
  localparam int          SEL_LSB       = 2;
  localparam int          CH_MSB        = 1;
  localparam int          CH_LSB        = 0;
  localparam logic [3:0]  OP_RD_WIPER   = 4'h9;
  localparam logic [3:0]  OP_WR_WIPER   = 4'hA;
  localparam logic [3:0]  OP_RD_SET     = 4'hB;
  localparam logic [3:0]  OP_WR_SET     = 4'hC;
  localparam logic [3:0]  OP_XFR_TO_WIP = 4'hD;
  localparam logic [3:0]  OP_XFR_TO_SET = 4'hE;
  localparam logic [7:0]  SET_RESET_VAL = 8'h80;
endpackage : pot_pkg

// [rtl/pot_nv_if.sv]
/*
  carrier between the serial engine and the register bank.
  assumes a single clock domain.
*/
`timescale 1ns/1ps
interface pot_nv_if;
  logic       wr_wiper;
  logic       wr_set;
  logic       xfr_to_wiper;
  logic       xfr_to_set;
  logic [1:0] ch;
  logic [1:0] sel;
  logic [7:0] wdata;
  logic [7:0] rd_wiper;
  logic [7:0] rd_set;
  logic       busy;
  modport engine (output wr_wiper, wr_set, xfr_to_wiper, xfr_to_set, ch,
                  sel, wdata, input rd_wiper, rd_set, busy);
  modport bank   (input wr_wiper, wr_set, xfr_to_wiper, xfr_to_set, ch,
                  sel, wdata, output rd_wiper, rd_set, busy);
endinterface : pot_nv_if

// [rtl/pot_pin_sync.sv]
/*
  three flop synchroniser with agreement filter.
  assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ps
module pot_pin_sync
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic pin,
  output logic      level
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic lvl_ff;
  logic nxt_lvl;

  always_comb
  begin
    nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
  end

  // idle bus level is high, so reset there
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_ff  <= 1'b1;
      s2_ff  <= 1'b1;
      s3_ff  <= 1'b1;
      lvl_ff <= 1'b1;
    end
    else
    begin
      s1_ff  <= pin;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  assign level = lvl_ff;
endmodule : pot_pin_sync

// [rtl/pot_bank.sv]
/*
  wiper and setting registers with timed nonvolatile write.
  assumes one command pulse at a time from the serial engine.
*/
`timescale 1ns/1ps
module pot_bank
  import pot_pkg::*;
#(
  parameter int NV_CYC = NV_WRITE_CYC
)
(
  input  wire logic   clk,
  input  wire logic   rstn,
  input  wire logic   wp_n,
  pot_nv_if.bank      nv,
  output logic [31:0] wiper_flat
);
  logic [7:0]  wip_ff [CH_NUM];
  logic [7:0]  nxt_wip [CH_NUM];
  logic [7:0]  set_ff [CH_NUM][SET_NUM];
  logic [7:0]  nxt_set [CH_NUM][SET_NUM];
  logic        rec_ff;
  logic        nxt_rec;
  logic [31:0] tmr_ff;
  logic [31:0] nxt_tmr;
  logic        nv_go;

  // settings model nonvolatile cells; flops reset to a mid-scale value
  assign nv_go = (nv.wr_set | nv.xfr_to_set) & wp_n; // R10

  always_comb
  begin
    nxt_wip = wip_ff;
    nxt_set = set_ff;
    nxt_rec = 1'b0;
    nxt_tmr = tmr_ff;
    if (rec_ff)
    begin
      for (int c = 0; c < CH_NUM; c++)
        nxt_wip[c] = set_ff[c][0]; // R3
    end
    else
    begin
      if (nv.wr_wiper)
        nxt_wip[nv.ch] = nv.wdata; // R12
      if (nv.xfr_to_wiper)
        nxt_wip[nv.ch] = set_ff[nv.ch][nv.sel]; // R12
      if (nv_go && tmr_ff == 32'h0)
      begin
        nxt_set[nv.ch][nv.sel] = nv.wr_set ? nv.wdata : wip_ff[nv.ch];
        nxt_tmr = 32'(NV_CYC); // R16
      end
      else if (tmr_ff != 32'h0)
        nxt_tmr = tmr_ff - 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rec_ff <= 1'b1;
      tmr_ff <= 32'h0;
      for (int c = 0; c < CH_NUM; c++)
      begin
        wip_ff[c] <= 8'h00;
        for (int s = 0; s < SET_NUM; s++)
          set_ff[c][s] <= SET_RESET_VAL;
      end
    end
    else
    begin
      rec_ff <= nxt_rec;
      tmr_ff <= nxt_tmr;
      wip_ff <= nxt_wip;
      set_ff <= nxt_set;
    end
  end

  assign nv.rd_wiper = wip_ff[nv.ch];
  assign nv.rd_set   = set_ff[nv.ch][nv.sel];
  assign nv.busy     = (tmr_ff != 32'h0) | rec_ff;
  assign wiper_flat  = {wip_ff[3], wip_ff[2], wip_ff[1], wip_ff[0]}; // R1 R2
endmodule : pot_bank

// [rtl/quad_pot_two_wire_slave.sv]
/*
  two-wire slave for four pot channels, oversampling the bus on clk.
  assumes scl and sda arrive asynchronously and a pull-up on sda.
*/
// What this block does
// R1: four channels, one wiper, four settings each
// R2: wiper code is eight bits, 256 taps
// R3: power-up copies setting 0 into wiper
// R4: sample data on rising serial clock
// R5: change output data after falling clock
// R6: drive data low or release only
// R7: low address bits from four straps
// R8: ignore transfers with mismatched address
// R9: at most sixteen distinct devices per bus
// R10: write-protect low blocks setting writes
// R11: master alone drives the serial clock
// R12: support write, read and transfer operations
// R13: first byte: type code plus strap address
// R14: ack identification, instruction, write data bytes
// R15: opcode, setting select, channel select fields
// R16: setting write lasts up to 10ms, busy
// R17: start and stop framed while clock high
// R18: msb first, ninth clock for acknowledge
`timescale 1ns/1ps
module quad_pot_two_wire_slave
  import pot_pkg::*;
#(
  parameter int NV_CYC = NV_WRITE_CYC
)
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        addr_strap_bit0,
  input  wire logic        addr_strap_bit1,
  input  wire logic        addr_strap_bit2,
  input  wire logic        addr_strap_bit3,
  input  wire logic        wp_n,
  output logic [7:0]       wiper0,
  output logic [7:0]       wiper1,
  output logic [7:0]       wiper2,
  output logic [7:0]       wiper3,
  output logic             nv_busy
);
  typedef enum {ST_IDLE, ST_ID, ST_INSTR, ST_WDATA, ST_RDATA, ST_RACK,
                ST_SKIP} state_t;

  pot_nv_if nv ();

  logic        scl;
  logic        sda;
  logic        scl_d_ff;
  logic        sda_d_ff;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic [31:0] wiper_flat;
  logic [3:0]  strap;
  logic        wp_sync_n;

  state_t      st_ff;
  state_t      nxt_st;
  logic [7:0]  sh_ff;
  logic [7:0]  nxt_sh;
  logic [3:0]  cnt_ff;
  logic [3:0]  nxt_cnt;
  logic [3:0]  op_ff;
  logic [3:0]  nxt_op;
  logic [1:0]  ch_ff;
  logic [1:0]  nxt_ch;
  logic [1:0]  sel_ff;
  logic [1:0]  nxt_sel;
  logic        oe_ff;
  logic        nxt_oe;
  logic        ack_ff;
  logic        nxt_ack;
  logic        wrw_ff;
  logic        nxt_wrw;
  logic        wrs_ff;
  logic        nxt_wrs;
  logic        xw_ff;
  logic        nxt_xw;
  logic        xs_ff;
  logic        nxt_xs;
  logic [7:0]  wd_ff;
  logic [7:0]  nxt_wd;
  logic [31:0] wip_o_ff;
  logic        busy_o_ff;

  ////////////////////////////////////////////////////////////////////////////
  pot_pin_sync u_scl
  (
    .clk   (clk),
    .rstn  (rstn),
    .pin   (scl_in),
    .level (scl)
  );

  pot_pin_sync u_sda
  (
    .clk   (clk),
    .rstn  (rstn),
    .pin   (sda_in),
    .level (sda)
  );
  pot_pin_sync u_wp
  (
    .clk   (clk),
    .rstn  (rstn),
    .pin   (wp_n),
    .level (wp_sync_n)
  );

  pot_bank #(.NV_CYC(NV_CYC)) u_bank
  (
    .clk        (clk),
    .rstn       (rstn),
    .wp_n       (wp_sync_n),
    .nv         (nv.bank),
    .wiper_flat (wiper_flat)
  );

  assign strap = {addr_strap_bit3, addr_strap_bit2,
                  addr_strap_bit1, addr_strap_bit0}; // R7

  assign scl_rise = scl & ~scl_d_ff;
  assign scl_fall = ~scl & scl_d_ff;
  assign start_c  = scl & scl_d_ff & sda_d_ff & ~sda; // R17
  assign stop_c   = scl & scl_d_ff & ~sda_d_ff & sda; // R17

  assign nv.wr_wiper     = wrw_ff;
  assign nv.wr_set       = wrs_ff;
  assign nv.xfr_to_wiper = xw_ff;
  assign nv.xfr_to_set   = xs_ff;
  assign nv.ch           = ch_ff;
  assign nv.sel          = sel_ff;
  assign nv.wdata        = wd_ff;

  ////////////////////////////////////////////////////////////////////////////
  // cnt 9 marks the ack rise, so the fall after start ends no byte
  always_comb
  begin
    nxt_st  = st_ff;
    nxt_sh  = sh_ff;
    nxt_cnt = cnt_ff;
    nxt_op  = op_ff;
    nxt_ch  = ch_ff;
    nxt_sel = sel_ff;
    nxt_oe  = oe_ff;
    nxt_ack = ack_ff;
    nxt_wrw = 1'b0;
    nxt_wrs = 1'b0;
    nxt_xw  = 1'b0;
    nxt_xs  = 1'b0;
    nxt_wd  = wd_ff;
    if (stop_c)
    begin
      nxt_st = ST_IDLE;
      nxt_oe = 1'b0;
    end
    else if (start_c)
    begin
      // bus ignored while the cell write runs
      nxt_st  = nv.busy ? ST_SKIP : ST_ID; // R16
      nxt_cnt = 4'h0;
      nxt_oe  = 1'b0;
    end
    else if (scl_rise)
    begin
      if (cnt_ff < 4'h8)
      begin
        nxt_sh  = {sh_ff[6:0], sda}; // R4 R18
        nxt_cnt = cnt_ff + 4'h1;
      end
      else
      begin
        nxt_cnt = 4'h9;
        if (st_ff == ST_RACK)
          nxt_ack = ~sda;
      end
    end
    else if (scl_fall)
    begin
      nxt_cnt = (cnt_ff == 4'h9) ? 4'h0 : cnt_ff;
      unique case (st_ff)
        ST_IDLE, ST_SKIP:
          nxt_oe = 1'b0;
        ST_ID:
        begin
          if (cnt_ff == 4'h8)
          begin
            if (sh_ff == {DEV_TYPE_ID, strap})
              nxt_oe = 1'b1; // R8 R13 R14
            else
              nxt_st = ST_SKIP; // R8
          end
          else if (cnt_ff == 4'h9)
          begin
            nxt_oe = 1'b0;
            nxt_st = ST_INSTR;
          end
        end
        ST_INSTR:
        begin
          if (cnt_ff == 4'h8)
          begin
            nxt_op  = sh_ff[OP_MSB:OP_LSB]; // R15
            nxt_sel = sh_ff[SEL_MSB:SEL_LSB]; // R15
            nxt_ch  = sh_ff[CH_MSB:CH_LSB]; // R15
            nxt_oe  = 1'b1; // R14
          end
          else if (cnt_ff == 4'h9)
          begin
            nxt_oe = 1'b0;
            unique case (op_ff)
              OP_WR_WIPER, OP_WR_SET:
                nxt_st = ST_WDATA;
              OP_RD_WIPER, OP_RD_SET:
              begin
                nxt_st = ST_RDATA;
                nxt_sh = (op_ff == OP_RD_WIPER) ? nv.rd_wiper : nv.rd_set;
                nxt_oe = ~nxt_sh[7]; // R5 R6
              end
              OP_XFR_TO_WIP:
              begin
                nxt_xw = 1'b1; // R12
                nxt_st = ST_SKIP;
              end
              OP_XFR_TO_SET:
              begin
                nxt_xs = 1'b1; // R12
                nxt_st = ST_SKIP;
              end
              default:
                nxt_st = ST_SKIP;
            endcase
          end
        end
        ST_WDATA:
        begin
          if (cnt_ff == 4'h8)
          begin
            nxt_oe  = 1'b1; // R14
            nxt_wd  = sh_ff;
            nxt_wrw = (op_ff == OP_WR_WIPER);
            nxt_wrs = (op_ff == OP_WR_SET);
          end
          else if (cnt_ff == 4'h9)
            nxt_oe = 1'b0;
        end
        ST_RDATA:
        begin
          if (cnt_ff == 4'h8)
          begin
            nxt_oe = 1'b0; // release for master ack
            nxt_st = ST_RACK;
          end
          else
          begin
            // the rise already shifted, so bit 7 is the next one out
            nxt_oe = ~sh_ff[7]; // R5 R6 R18
          end
        end
        ST_RACK:
        begin
          if (cnt_ff == 4'h9 && ack_ff)
          begin
            nxt_st = ST_RDATA;
            nxt_sh = (op_ff == OP_RD_WIPER) ? nv.rd_wiper : nv.rd_set;
            nxt_oe = ~nxt_sh[7]; // R5 R6
          end
          else if (cnt_ff == 4'h9)
            nxt_st = ST_SKIP;
        end
        default:
          nxt_st = ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_d_ff  <= 1'b1;
      sda_d_ff  <= 1'b1;
      st_ff     <= ST_IDLE;
      sh_ff     <= 8'h00;
      cnt_ff    <= 4'h0;
      op_ff     <= 4'h0;
      ch_ff     <= 2'h0;
      sel_ff    <= 2'h0;
      oe_ff     <= 1'b0;
      ack_ff    <= 1'b0;
      wrw_ff    <= 1'b0;
      wrs_ff    <= 1'b0;
      xw_ff     <= 1'b0;
      xs_ff     <= 1'b0;
      wd_ff     <= 8'h00;
      wip_o_ff  <= 32'h0;
      busy_o_ff <= 1'b1;
    end
    else
    begin
      scl_d_ff  <= scl;
      sda_d_ff  <= sda;
      st_ff     <= nxt_st;
      sh_ff     <= nxt_sh;
      cnt_ff    <= nxt_cnt;
      op_ff     <= nxt_op;
      ch_ff     <= nxt_ch;
      sel_ff    <= nxt_sel;
      oe_ff     <= nxt_oe;
      ack_ff    <= nxt_ack;
      wrw_ff    <= nxt_wrw;
      wrs_ff    <= nxt_wrs;
      xw_ff     <= nxt_xw;
      xs_ff     <= nxt_xs;
      wd_ff     <= nxt_wd;
      wip_o_ff  <= wiper_flat;
      busy_o_ff <= nv.busy;
    end
  end

  // never driven high: open drain
  assign sda_out = 1'b0; // R6
  assign sda_oe  = oe_ff;
  assign wiper0  = wip_o_ff[7:0];
  assign wiper1  = wip_o_ff[15:8];
  assign wiper2  = wip_o_ff[23:16];
  assign wiper3  = wip_o_ff[31:24];
  assign nv_busy = busy_o_ff;
endmodule : quad_pot_two_wire_slave

// [dv/quad_pot_props.sv]
/*
  assertions on the quad pot slave top ports.
  assumes NV_CYC equals the value given to the instance.
*/
`timescale 1ns/1ps
module quad_pot_props
  import pot_pkg::*;
#(
  parameter int NV_CYC = NV_WRITE_CYC
)
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [7:0] wiper0,
  input wire logic [7:0] wiper1,
  input wire logic [7:0] wiper2,
  input wire logic [7:0] wiper3,
  input wire logic       nv_busy
);
  logic [31:0] wipers;
  logic [31:0] busy_ff;
  logic [31:0] nxt_busy;
  logic [3:0]  up_ff;
  logic [3:0]  nxt_up;
  assign wipers = {wiper3, wiper2, wiper1, wiper0};
  // up_ff hides the power-up recall from the wiper-on-ack check
  always_comb
  begin
    nxt_busy = nv_busy ? busy_ff + 32'h1 : 32'h0;
    nxt_up   = (up_ff == 4'hF) ? up_ff : up_ff + 4'h1;
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_ff <= 32'h0;
      up_ff   <= 4'h0;
    end
    else
    begin
      busy_ff <= nxt_busy;
      up_ff   <= nxt_up;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_sda_low_only: assert property (!sda_out)
    else $error("data driven high");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data moved while clock high");
  a_oe_stands: assert property ($changed(sda_oe) |=> $stable(sda_oe) [*8])
    else $error("data bit too short");
  a_recall_wiper: assert property ($rose(rstn) |-> ##[0:3]
    wipers == {4{SET_RESET_VAL}})
    else $error("no recall");
  a_busy_clears: assert property ($rose(rstn) |-> ##[1:4] !nv_busy)
    else $error("busy after recall");
  a_busy_no_ack: assert property ($rose(sda_oe) |-> !nv_busy)
    else $error("ack while busy");
  a_busy_bound: assert property (busy_ff <= NV_CYC + 8)
    else $error("write too long");
  // wipers move two clocks after the ack edge that launched them
  a_wiper_on_ack: assert property (up_ff == 4'hF && !$stable(wipers)
    |-> $past(sda_oe, 2) != $past(sda_oe, 3))
    else $error("wiper moved off ack");
  c_ack: cover property ($rose(sda_oe));
  c_busy: cover property (busy_ff == 32'd100);
  c_wiper: cover property (up_ff == 4'hF && !$stable(wipers));
endmodule : quad_pot_props
bind quad_pot_two_wire_slave quad_pot_props #(.NV_CYC(NV_CYC)) props_u
(
  .clk     (clk),
  .rstn    (rstn),
  .scl_in  (scl_in),
  .sda_out (sda_out),
  .sda_oe  (sda_oe),
  .wiper0  (wiper0),
  .wiper1  (wiper1),
  .wiper2  (wiper2),
  .wiper3  (wiper3),
  .nv_busy (nv_busy)
);

// [dv/pot_bus_master.sv]
/*
  two-wire bus master model, open drain on data.
  assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ps
module pot_bus_master
(
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl = 1'b1,
  output logic      pull_low = 1'b0
);
  int hp = 12;
  ////////////////////////////////////////
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic bit_x(input logic b, output logic r);
    wt(4);
    pull_low <= ~b;
    wt(hp);
    scl <= 1'b1;
    wt(hp);
    r = sda;
    scl <= 1'b0;
  endtask : bit_x
  task automatic byte_x(input logic [7:0] d, input logic ak,
                        output logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], v[i]);
    bit_x(ak, ack);
  endtask : byte_x
  task automatic xfer(input logic [7:0] id, ins, dat, input int mode,
                      output logic [2:0] ack, output logic [7:0] rd);
    logic [7:0] junk;
    ack = 3'b111;
    rd  = 8'h00;
    wt(hp);
    pull_low <= 1'b1;
    wt(hp);
    scl <= 1'b0;
    byte_x(id, 1'b1, junk, ack[0]);
    if (ack[0] === 1'b0)
    begin
      byte_x(ins, 1'b1, junk, ack[1]);
      if (mode == 1)
        byte_x(dat, 1'b1, junk, ack[2]);
      // nack after one byte ends the read
      if (mode == 2)
        byte_x(8'hFF, 1'b1, rd, junk[0]);
    end
    wt(4);
    pull_low <= 1'b1;
    wt(hp);
    scl <= 1'b1;
    wt(hp);
    pull_low <= 1'b0;
    wt(hp);
  endtask : xfer
endmodule : pot_bus_master

// [dv/testbench.sv]
/*
  self-checking bench for the quad pot two-wire slave.
  assumes the master model and a pull-up on the data wire.
*/
`timescale 1ns/1ps
module testbench
  import pot_pkg::*;
();
  localparam int NV_T = 2000;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       wp_n = 1'b1;
  logic [3:0] strap = 4'h6;
  logic       scl, pull_low, sda, sda_out, sda_oe, nv_busy;
  logic [7:0] w [4];
  logic [2:0] a;
  logic [7:0] v;
  int         bad_count = 0;
  int         check_count = 0;
  int         cyc = 0;
  always #20 clk = ~clk;
  assign sda = !(pull_low || (sda_oe && !sda_out));
  quad_pot_two_wire_slave #(.NV_CYC(NV_T)) dut_u
  (
    .clk             (clk),
    .rstn            (rstn),
    .scl_in          (scl),
    .sda_in          (sda),
    .sda_out         (sda_out),
    .sda_oe          (sda_oe),
    .addr_strap_bit0 (strap[0]),
    .addr_strap_bit1 (strap[1]),
    .addr_strap_bit2 (strap[2]),
    .addr_strap_bit3 (strap[3]),
    .wp_n            (wp_n),
    .wiper0          (w[0]),
    .wiper1          (w[1]),
    .wiper2          (w[2]),
    .wiper3          (w[3]),
    .nv_busy         (nv_busy)
  );
  pot_bus_master m_u
  (
    .clk      (clk),
    .sda      (sda),
    .scl      (scl),
    .pull_low (pull_low)
  );
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic end_sim();
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic tx(input logic [3:0] op, input logic [1:0] sel, ch,
                    input logic [7:0] d, input int mode);
    m_u.xfer({DEV_TYPE_ID, strap}, {op, sel, ch}, d, mode, a, v);
  endtask : tx
  task automatic nv_wait();
    for (int n = 0; n < 2 * NV_T && nv_busy !== 1'b0; n++)
      @(posedge clk);
    chk("busy", {7'h0, nv_busy}, 8'h00);
  endtask : nv_wait
  task automatic t_reset();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (20) @(posedge clk);
    for (int c = 0; c < 4; c++)
      chk("wiper", w[c], SET_RESET_VAL);
    nv_wait();
  endtask : t_reset
  task automatic t_wiper();
    logic [7:0] d [4];
    for (int c = 0; c < 4; c++)
    begin
      d[c] = 8'hC5 - 8'(c * 59);
      tx(OP_WR_WIPER, 2'h0, 2'(c), d[c], 1);
      chk("wr_ack", {5'h0, a}, 8'h00);
      tx(OP_RD_WIPER, 2'h0, 2'(c), 8'h00, 2);
      chk("rd_wiper", v, d[c]);
    end
    for (int c = 0; c < 4; c++)
      chk("wiper", w[c], d[c]);
  endtask : t_wiper
  task automatic t_addr();
    for (int i = 0; i < 2; i++)
    begin
      m_u.xfer(i ? {~DEV_TYPE_ID, strap} : {DEV_TYPE_ID, ~strap},
               {OP_WR_WIPER, 4'h0}, 8'h00, 1, a, v);
      chk("id_nack", {5'h0, a}, 8'h07);
    end
    chk("wiper0", w[0], 8'hC5);
    strap <= 4'h9;
    repeat (10) @(posedge clk);
    tx(OP_WR_WIPER, 2'h0, 2'h0, 8'h21, 1);
    chk("wiper0", w[0], 8'h21);
  endtask : t_addr
  task automatic t_setting();
    tx(OP_WR_SET, 2'h3, 2'h2, 8'h5A, 1);
    chk("set_ack", {5'h0, a}, 8'h00);
    tx(OP_XFR_TO_WIP, 2'h3, 2'h2, 8'h00, 0);
    chk("busy_nack", {5'h0, a}, 8'h07);
    nv_wait();
    tx(OP_XFR_TO_WIP, 2'h3, 2'h2, 8'h00, 0);
    chk("wiper2", w[2], 8'h5A);
  endtask : t_setting
  task automatic t_protect();
    wp_n <= 1'b0;
    tx(OP_WR_SET, 2'h3, 2'h2, 8'hA5, 1);
    nv_wait();
    tx(OP_XFR_TO_SET, 2'h3, 2'h0, 8'h00, 0);
    nv_wait();
    tx(OP_RD_SET, 2'h3, 2'h2, 8'h00, 2);
    chk("set_kept", v, 8'h5A);
    tx(OP_RD_SET, 2'h3, 2'h0, 8'h00, 2);
    chk("set_kept", v, SET_RESET_VAL);
    wp_n <= 1'b1;
  endtask : t_protect
  task automatic t_slow();
    m_u.hp = 30;
    tx(OP_WR_WIPER, 2'h0, 2'h1, 8'h3D, 1);
    tx(OP_XFR_TO_SET, 2'h1, 2'h1, 8'h00, 0);
    nv_wait();
    tx(OP_WR_WIPER, 2'h0, 2'h1, 8'h00, 1);
    tx(OP_XFR_TO_WIP, 2'h1, 2'h1, 8'h00, 0);
    chk("wiper1", w[1], 8'h3D);
    tx(OP_RD_SET, 2'h1, 2'h1, 8'h00, 2);
    chk("rd_set", v, 8'h3D);
    m_u.hp = 12;
  endtask : t_slow
  ////////////////////////////////////////
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 95000)
    begin
      bad_count++;
      end_sim();
    end
  end
  initial
  begin
    t_reset();
    t_wiper();
    t_addr();
    t_setting();
    t_protect();
    t_slow();
    t_reset();
    end_sim();
  end
endmodule : testbench
